// ---- rx_port_pkg.sv ----
// Purpose: Shared constants and types for the receive parallel output port.
// Assumes: Wishbone data is 32 bits and byte addressed.
// Notes:   Register offsets are byte addresses of aligned words.
package rx_port_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MASK   = 8'h08;
   localparam logic [7:0] ADDR_STATE  = 8'h0c;

   // ==========================================================
   // Field layout and reset values
   localparam int          WORD_W        = 10;
   localparam int          CODE_W        = 3;
   localparam int          EVT_W         = 3;
   localparam int          EVT_CHAR      = 0;
   localparam int          EVT_CODE      = 1;
   localparam int          EVT_PWR       = 2;
   localparam logic [1:0]  SELFTEST_OFF  = 2'h0;
   localparam logic [1:0]  SELFTEST_RECV = 2'h2;
   localparam logic [4:0]  CTRL_RESET    = 5'h00;
   localparam logic [EVT_W-1:0] EVT_ZERO = 3'h0;

   typedef struct packed {
      logic       enableTwo;
      logic       enableOne;
      logic [1:0] selftest;
      logic       halfRate;
   } ctrl_s;

   typedef struct packed {
      logic              clkTrue;
      logic              clkComp;
      logic [WORD_W-1:0] word;
      logic              status;
   } link_out_s;

endpackage

// ---- sync_two_stage.sv ----
// Purpose: Two flip-flop synchroniser for levels from another domain.
// Assumes: Each bit is a slow level or is stable around the sampling edge.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/100ps
`default_nettype none
module sync_two_stage #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] async,
   output var  logic [W-1:0] synced
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= '0;
         synced <= '0;
      end else if (ce) begin
         meta_q <= async;
         synced <= meta_q;
      end
   end
endmodule // sync_two_stage
`default_nettype wire

// ---- rx_parallel_output_port.sv ----
// Purpose: Presents recovered characters and self-test status on a parallel
//          bus timed by a complementary output clock pair.
// Assumes: The recovered character clock and the data beside it come from
//          another domain; each character stays stable for at least four
//          clk periods around its rising edge.
// Notes:   The output pair is rebuilt from sampled edges, so it carries up
//          to one clk period of jitter.
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Full rate: complementary pair at character rate; data follows true rise.
// - Half rate: clocks at half character rate, data changes on both edges.
// - Self-test enabled: status code shown on the two lowest data bits.
// - Control binary 10: status line and low bits report self-test reception.
// - Power-down flag is high while reclocker output logic is powered down.
// - Reclocker powered down exactly when both output enables are zero.
// - Output clock runs at one tenth or one twentieth of bit rate.
// - Asynchronous active-low reset returns all state to its initial value.
module rx_parallel_output_port (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        ce,
   input  wire logic        charClk,
   input  wire logic [9:0]  charWord,
   input  wire logic [2:0]  selftestCode,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   output var  logic        recoveredOutputClockTrue,
   output var  logic        recoveredOutputClockComp,
   output var  logic [9:0]  recoveredParallelWord,
   output var  logic        selftestStatusLine,
   output var  logic        reclockerPowerdownFlag,
   output var  logic        irq
);
   // ==========================================================
   // Input crossing
   localparam int SW = 1 + rx_port_pkg::WORD_W + rx_port_pkg::CODE_W;
   logic [SW-1:0] syncIn;
   logic          clkSync;
   logic          clkPrev_q;
   logic [9:0]    wordSync;
   logic [2:0]    codeSync;

   sync_two_stage #(.W(SW)) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .ce      (ce),
      .async   ({charClk, charWord, selftestCode}),
      .synced  (syncIn)
   );

   assign clkSync  = syncIn[SW-1];
   assign wordSync = syncIn[SW-2 -: rx_port_pkg::WORD_W];
   assign codeSync = syncIn[rx_port_pkg::CODE_W-1:0];

   // ==========================================================
   // Control and status registers
   rx_port_pkg::ctrl_s           ctrl_q;
   logic [rx_port_pkg::EVT_W-1:0] status_q;
   logic [rx_port_pkg::EVT_W-1:0] mask_q;
   logic [rx_port_pkg::EVT_W-1:0] events;
   logic [rx_port_pkg::EVT_W-1:0] status_d;
   logic [rx_port_pkg::EVT_W-1:0] clearBits;
   logic [2:0]                    lastCode_q;
   logic                          charRise;
   logic                          charFall;
   logic                          selftestOn;
   logic                          statusValid;
   logic                          powerDown;

   assign charRise    = clkSync & ~clkPrev_q;
   assign charFall    = ~clkSync & clkPrev_q;
   assign selftestOn  = ctrl_q.selftest != rx_port_pkg::SELFTEST_OFF;
   assign statusValid = ctrl_q.selftest == rx_port_pkg::SELFTEST_RECV;
   assign powerDown   = ~(ctrl_q.enableOne | ctrl_q.enableTwo);

   // ==========================================================
   // Output clock pair and data
   rx_port_pkg::link_out_s out_q;
   rx_port_pkg::link_out_s out_d;
   logic [9:0]             wordNext;

   // in self-test the low bits carry the code; the status line carries its top bit only in receive self-test.
   assign wordNext = selftestOn ? {8'h00, codeSync[1:0]} : wordSync;
   // Half rate toggles the pair on every character, so data moves with
   // both of its edges; full rate copies the character clock itself.
   assign out_d.clkTrue = ctrl_q.halfRate ? (out_q.clkTrue ^ charRise)
                                          : (charRise | (out_q.clkTrue
                                             & ~charFall));
   assign out_d.clkComp = ~out_d.clkTrue;
   assign out_d.word    = charRise ? wordNext : out_q.word;
   // Outside receive self-test each character loads the line low as a defined value.
   assign out_d.status  = charRise ? (statusValid & codeSync[2])
                                   : out_q.status;

   // ==========================================================
   // Events and interrupt
   assign events[rx_port_pkg::EVT_CHAR] = charRise;
   assign events[rx_port_pkg::EVT_CODE] = charRise & selftestOn
                                          & (codeSync != lastCode_q);
   assign events[rx_port_pkg::EVT_PWR]  = powerDown
                                          != reclockerPowerdownFlag;

   // ==========================================================
   // Wishbone slave
   logic        wbReq;
   logic        wbWrite;
   logic [31:0] rdData;
   logic [31:0] wrMasked;
   logic [31:0] ctrlWide;
   logic [31:0] ctrlMerged;

   function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   assign wbReq    = wb_cyc_i & wb_stb_i;
   // A write lands on the edge that also sees ack, as the master expects.
   assign wbWrite  = wbReq & wb_we_i & wb_ack_o;
   assign ctrlWide = {27'h0, ctrl_q};
   assign ctrlMerged = laneMerge(ctrlWide, wb_dat_i, wb_sel_i);
   assign wrMasked = laneMerge(32'h00000000, wb_dat_i, wb_sel_i);
   assign clearBits = (wbWrite && wb_adr_i == rx_port_pkg::ADDR_STATUS)
                      ? wrMasked[rx_port_pkg::EVT_W-1:0]
                      : rx_port_pkg::EVT_ZERO;
   // A set in the same cycle as its clear wins.
   assign status_d = (status_q & ~clearBits) | events;
   assign rdData =
      (wb_adr_i == rx_port_pkg::ADDR_CTRL)   ? ctrlWide :
      (wb_adr_i == rx_port_pkg::ADDR_STATUS) ? {29'h0, status_q} :
      (wb_adr_i == rx_port_pkg::ADDR_MASK)   ? {29'h0, mask_q} :
      (wb_adr_i == rx_port_pkg::ADDR_STATE)  ?
         {27'h0, reclockerPowerdownFlag, ctrl_q.halfRate, lastCode_q} :
      32'h00000000;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else if (ce) begin
         wb_ack_o <= wbReq & ~wb_ack_o;
         wb_dat_o <= (wbReq & ~wb_ack_o) ? rdData : 32'h00000000;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= rx_port_pkg::CTRL_RESET;
         mask_q <= rx_port_pkg::EVT_ZERO;
      end else if (ce && wbWrite) begin
         if (wb_adr_i == rx_port_pkg::ADDR_CTRL) begin
            ctrl_q <= ctrlMerged[rx_port_pkg::WORD_W/2-1:0];
         end
         if (wb_adr_i == rx_port_pkg::ADDR_MASK) begin
            mask_q <= wrMasked[rx_port_pkg::EVT_W-1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clkPrev_q              <= 1'b0;
         out_q                  <= '{clkComp: 1'b1, default: '0};
         lastCode_q             <= 3'h0;
         status_q               <= rx_port_pkg::EVT_ZERO;
         reclockerPowerdownFlag <= 1'b0;
         irq                    <= 1'b0;
      end else if (ce) begin
         clkPrev_q              <= clkSync;
         out_q                  <= out_d;
         lastCode_q             <= charRise ? codeSync : lastCode_q;
         status_q               <= status_d;
         reclockerPowerdownFlag <= powerDown;
         irq                    <= |(status_q & mask_q);
      end
   end

   assign recoveredOutputClockTrue = out_q.clkTrue;
   assign recoveredOutputClockComp = out_q.clkComp;
   assign recoveredParallelWord    = out_q.word;
   assign selftestStatusLine       = out_q.status;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_charTaken;
      ce && charRise;
   endsequence

   a_pair_complement: assert property (
      out_q.clkTrue != out_q.clkComp)
      else $error("Output clock pair not complementary.");
   a_full_rise_data: assert property (
      s_charTaken ##0 !ctrl_q.halfRate ##0 !out_q.clkTrue
      |=> out_q.clkTrue && out_q.word == $past(wordNext))
      else $error("Full rate data did not move with rising clock.");
   a_half_toggle: assert property (
      s_charTaken ##0 ctrl_q.halfRate
      |=> out_q.clkTrue != $past(out_q.clkTrue)
          && out_q.word == $past(wordNext))
      else $error("Half rate edge did not carry new data.");
   a_half_hold: assert property (
      ce && ctrl_q.halfRate && !charRise |=> $stable(out_q.clkTrue))
      else $error("Half rate clock moved without a character.");
   a_selftest_bits: assert property (
      s_charTaken ##0 selftestOn
      |=> out_q.word[1:0] == $past(codeSync[1:0])
          && out_q.word[9:2] == 8'h00)
      else $error("Self-test code missing on low data bits.");
   a_status_code: assert property (
      s_charTaken ##0 statusValid
      |=> out_q.status == $past(codeSync[2]))
      else $error("Status line does not match the self-test code.");
   a_powerdown_flag: assert property (
      reset_n && ce |=> reclockerPowerdownFlag
      == $past(!(ctrl_q.enableOne || ctrl_q.enableTwo)))
      else $error("Power-down flag disagrees with output enables.");
   a_reset_state: assert property (
      $rose(reset_n) |-> ctrl_q == rx_port_pkg::CTRL_RESET
      && out_q.word == 10'h000 && !irq)
      else $error("State not initial after reset.");
   a_irq_level: assert property (
      ce |=> irq == $past(|(status_q & mask_q)))
      else $error("Interrupt does not follow masked status.");

endmodule // rx_parallel_output_port
`default_nettype wire

// ---- rx_far_side_model.sv ----
// Purpose: Downstream logic that captures recovered characters.
// Assumes: Full rate captures on a rising true clock, half rate on both.
// Notes:   Bits it must ignore are zeroed, so the bench compares all 11.
`timescale 1ns/100ps
`default_nettype none
module rx_far_side_model (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire logic                   halfRate,
   input  wire logic [1:0]             selftest,
   input  wire rx_port_pkg::link_out_s link,
   output var  logic                   capValid,
   output var  logic [10:0]            capData
);
   // ==========================================================
   // Capture
   logic       prevTrue;
   wire  logic edgeSeen;
   wire  logic [9:0] useWord;
   wire  logic useStatus;
   assign edgeSeen = halfRate ? (link.clkTrue != prevTrue)
                              : (link.clkTrue && !prevTrue);
   assign useWord = (selftest != 2'h0) ? {8'h00, link.word[1:0]}
                                       : link.word;
   assign useStatus = (selftest == 2'h2) ? link.status : 1'b0;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prevTrue <= 1'b0;
         capValid <= 1'b0;
         capData  <= 11'h000;
      end else begin
         prevTrue <= link.clkTrue;
         capValid <= edgeSeen;
         capData  <= {useStatus, useWord};
      end
   end
endmodule // rx_far_side_model
`default_nettype wire

// ---- rx_parallel_output_port_tb.sv ----
// Purpose: Self-checking bench for the receive parallel output port.
// Assumes: One character every 200 ns; ack comes one cycle after a request.
// Notes:   Captures are checked in order against a queue of notes.
`timescale 1ns/100ps
`default_nettype none
module rx_parallel_output_port_tb;
   // ==========================================================
   // Signals
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        ce = 1'b1;
   logic        charClk = 1'b0;
   logic [9:0]  charWord = 10'h000;
   logic [2:0]  selftestCode = 3'h0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'hf;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] dato;
   logic        ack, irq, pdFlag, capValid;
   logic [10:0] capData;
   logic        halfRate = 1'b0;
   logic [1:0]  stMode = 2'h0;
   logic [31:0] seed = 32'h4700;
   rx_port_pkg::link_out_s link;
   logic [10:0] expQ[$];
   int          failures = 0;
   int          cmpCount = 0;
   int          cycles = 0;
   always #12.5 clk = ~clk;
   rx_parallel_output_port u_dut (.clk(clk), .reset_n(reset_n), .ce(ce),
      .charClk(charClk), .charWord(charWord), .selftestCode(selftestCode),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
      .recoveredOutputClockTrue(link.clkTrue),
      .recoveredOutputClockComp(link.clkComp),
      .recoveredParallelWord(link.word), .selftestStatusLine(link.status),
      .reclockerPowerdownFlag(pdFlag), .irq(irq));
   rx_far_side_model u_far (.clk(clk), .reset_n(reset_n),
      .halfRate(halfRate), .selftest(stMode), .link(link),
      .capValid(capValid), .capData(capData));
   // ==========================================================
   // Tasks
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("Counts: %0d compares, %0d mismatches", cmpCount, failures);
      if (failures == 0 && cmpCount > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      r = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic sendChar(input logic [9:0] w, input logic [2:0] c);
      expQ.push_back({(stMode == 2'h2) ? c[2] : 1'b0,
                      (stMode != 2'h0) ? {8'h00, c[1:0]} : w});
      charWord <= w;
      selftestCode <= c;
      repeat (2) @(posedge clk);
      charClk <= 1'b1;
      repeat (4) @(posedge clk);
      charClk <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic runChars(input logic h, input logic [1:0] m);
      halfRate <= h;
      stMode <= m;
      wb(1'b1, rx_port_pkg::ADDR_CTRL, {27'h0, 2'b01, m, h}, rdat);
      repeat (5) begin
         seed = xs(seed);
         sendChar(seed[9:0], seed[12:10]);
      end
      repeat (8) @(posedge clk);
      $display("test chars mode %0d rate %0d done", m, h);
   endtask
   // ==========================================================
   // Checking of captures and timeout
   always @(posedge clk) begin
      if (capValid === 1'b1) begin
         if (expQ.size() == 0) check(32'h0, 32'h1);
         else check(32'(capData), 32'(expQ.pop_front()));
         check(32'(link.clkComp ^ link.clkTrue), 32'h1);
      end
      cycles++;
      if (cycles > 20000) begin
         failures++;
         complete_run();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      wb(1'b0, rx_port_pkg::ADDR_CTRL, 32'h0, rdat);
      check(rdat, 32'h0);
      check(32'(pdFlag), 32'h1);
      wb(1'b0, 8'h10, 32'h0, rdat);
      check(rdat, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, rx_port_pkg::ADDR_CTRL, 32'(i << 3), rdat);
         repeat (3) @(posedge clk);
         check(32'(pdFlag), 32'(i == 0));
      end
      $display("test power done");
      runChars(1'b0, 2'h0);
      for (int m = 1; m < 4; m++) runChars(1'b0, 2'(m));
      runChars(1'b1, 2'h0);
      wb(1'b1, rx_port_pkg::ADDR_MASK, 32'h1, rdat);
      repeat (3) @(posedge clk);
      check(32'(irq), 32'h1);
      wb(1'b1, rx_port_pkg::ADDR_STATUS, 32'h7, rdat);
      wb(1'b1, rx_port_pkg::ADDR_MASK, 32'h0, rdat);
      sendChar(10'h2a5, 3'h0);
      repeat (8) @(posedge clk);
      check(32'(irq), 32'h0);
      wb(1'b0, rx_port_pkg::ADDR_STATUS, 32'h0, rdat);
      check(32'(rdat[0]), 32'h1);
      $display("test interrupt done");
      ce <= 1'b0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= 1'b0;
      adr <= rx_port_pkg::ADDR_STATE;
      repeat (4) @(posedge clk);
      check(32'(ack), 32'h0);
      ce <= 1'b1;
      wb(1'b0, rx_port_pkg::ADDR_STATE, 32'h0, rdat);
      check(rdat, 32'h8);
      $display("test enable done");
      reset_n <= 1'b0;
      @(posedge clk);
      check(32'(link), 32'h800);
      reset_n <= 1'b1;
      @(posedge clk);
      wb(1'b0, rx_port_pkg::ADDR_CTRL, 32'h0, rdat);
      check(rdat, 32'h0);
      check(32'(expQ.size()), 32'h0);
      $display("test reset done");
      complete_run();
   end
endmodule // rx_parallel_output_port_tb
`default_nettype wire
